/* core/gmc_pkg.sv */
// Package: register map, field positions and carrier types for the global/memory config block
package gmc_pkg;
    localparam logic [15:0] GMC_ADDR_MEM_CFG = 16'hffb0;
    localparam logic [15:0] GMC_ADDR_GLOB_CTL = 16'hffb1;
    localparam logic [7:0] GMC_GLOB_CTL_RESET = 8'h00;
    localparam int GMC_BIT_CLK_SEL = 7;
    localparam int GMC_BIT_EXT_IRQ_EN = 6;
    localparam int GMC_BIT_P1_PU_OFF = 5;
    localparam int GMC_BIT_GPIO4 = 4;
    localparam int GMC_BIT_GPIO3 = 3;
    localparam int GMC_BIT_USB_PWR = 2;
    localparam int GMC_BIT_P3_PU_OFF = 1;
    localparam int GMC_BIT_CODEC_EN = 0;
    localparam int GMC_BIT_BOOT_SHADOW = 0;
    localparam logic GMC_CODE_MEM_KIND = 1'b1;
    localparam logic [1:0] GMC_CODE_SPACE_SIZE = 2'h1;
    // Silicon revision value is arbitrary
    localparam logic [3:0] GMC_SILICON_REV = 4'h5;
    localparam logic [7:0] GMC_UNMAPPED_READ = 8'h00;
    localparam int GMC_CLK_SLOW_MHZ = 12;
    localparam int GMC_CLK_FAST_MHZ = 24;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gmc_bus_req_t;

    typedef struct packed {
        logic cpu_clock_speed_select;
        logic ext_irq_enable;
        logic port_one_pullup_off;
        logic gpio_out_bit4;
        logic gpio_out_bit3;
        logic usb_power_on;
        logic port_three_pullup_off;
        logic codec_port_enable;
    } gmc_glob_ctl_t;
endpackage

/* core/gmc_sticky_bit.sv */
// Sticky set-only bit cleared only by reset
`timescale 1ns/1ps
`default_nettype none
module gmc_sticky_bit (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Set request
    input wire logic set_req,
    // Stored value
    output logic value
);
    typedef struct packed {
        logic bit_r;
    } gmc_sticky_state_t;

    gmc_sticky_state_t st_r;
    gmc_sticky_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (set_req) begin
            st_nxt.bit_r = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value = st_r.bit_r;
endmodule
`default_nettype wire

/* core/gmc_irq_sync.sv */
// Two-stage synchroniser with enable gating for the external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module gmc_irq_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pin and gate
    input wire logic pin_in,
    input wire logic enable,
    // Gated level
    output logic irq_out
);
    typedef struct packed {
        logic s1_r;
        logic s2_r;
    } gmc_sync_state_t;

    gmc_sync_state_t st_r;
    gmc_sync_state_t st_nxt;

    always_comb begin
        st_nxt.s1_r = pin_in;
        st_nxt.s2_r = st_r.s1_r;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign irq_out = st_r.s2_r & enable;
endmodule
`default_nettype wire

/* core/gmc_config_regs.sv */
// Global control and memory configuration registers
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Clock select 0 means 12 MHz controller clock, 1 means 24 MHz.
// R2: Clock select is sticky once set; only master reset clears it.
// R3: External interrupt input accepted only while its enable bit is set.
// R4: Port-one pullups off while port-one pullup disable bit is set.
// R5: Port-three pullups off while port-three pullup disable bit is set.
// R6: Bits 4 and 3 drive dedicated GPIO output pins directly.
// R7: USB blocks powered down while low-power bit is 0, the reset value.
// R8: Firmware sets low-power bit before expecting USB operation.
// R9: Codec port runs only while its enable bit is set.
// R10: Firmware programs codec configuration before enabling the codec port.
// R11: Code memory type bit reads fixed 1, meaning 8K RAM.
// R12: Code space size field reads fixed 01b, meaning 8K bytes.
// R13: Revision field bits 4:1 are hardwired and ignore writes.
// R14: Writing 1 to boot-shadow switches memory map to normal mode.
// R15: Boot firmware sets boot-shadow only after code download completes.
// R16: Boot-shadow writes are gated by an external protection bit.
// R17: Gated external interrupt ORed with internal sources onto interrupt line.
module gmc_config_regs
    import gmc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupts
    input wire logic ext_irq_pin,
    input wire logic internal_irq_any,
    output logic cpu_interrupt_line,
    output logic ext_irq_gated,
    // Boot-shadow protection from USB control register
    input wire logic boot_shadow_protect,
    // Controls
    output logic cpu_clock_speed_select,
    output logic port_one_pullup_off,
    output logic port_three_pullup_off,
    output logic gpio_out_bit4,
    output logic gpio_out_bit3,
    output logic usb_power_down,
    output logic codec_port_enable,
    output logic boot_shadow
);
    typedef struct packed {
        gmc_glob_ctl_t glob_r;
        logic boot_shadow_r;
        logic [7:0] rdata_r;
    } gmc_regs_state_t;

    gmc_regs_state_t st_r;
    gmc_regs_state_t st_nxt;
    gmc_bus_req_t req;
    logic clk_sel_value;
    logic clk_sel_set;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction

    function automatic logic [7:0] mem_cfg_value(input logic shadow);
        mem_cfg_value = {GMC_CODE_MEM_KIND, GMC_CODE_SPACE_SIZE, GMC_SILICON_REV, shadow};
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Sticky clock select
    assign clk_sel_set = req.wr && hit(req.addr, GMC_ADDR_GLOB_CTL)
        && req.wdata[GMC_BIT_CLK_SEL]; // R2

    gmc_sticky_bit u_clk_sel (
        .clk(clk),
        .reset_n(reset_n),
        .set_req(clk_sel_set),
        .value(clk_sel_value)
    );

    // Register update and read
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata_r = GMC_UNMAPPED_READ;
        st_nxt.glob_r.cpu_clock_speed_select = clk_sel_value; // R2
        if (req.wr && hit(req.addr, GMC_ADDR_GLOB_CTL)) begin
            st_nxt.glob_r.ext_irq_enable = req.wdata[GMC_BIT_EXT_IRQ_EN];
            st_nxt.glob_r.port_one_pullup_off = req.wdata[GMC_BIT_P1_PU_OFF];
            st_nxt.glob_r.gpio_out_bit4 = req.wdata[GMC_BIT_GPIO4];
            st_nxt.glob_r.gpio_out_bit3 = req.wdata[GMC_BIT_GPIO3];
            st_nxt.glob_r.usb_power_on = req.wdata[GMC_BIT_USB_PWR];
            st_nxt.glob_r.port_three_pullup_off = req.wdata[GMC_BIT_P3_PU_OFF];
            st_nxt.glob_r.codec_port_enable = req.wdata[GMC_BIT_CODEC_EN];
        end
        if (req.wr && hit(req.addr, GMC_ADDR_MEM_CFG) && !boot_shadow_protect) begin
            st_nxt.boot_shadow_r = req.wdata[GMC_BIT_BOOT_SHADOW]; // R14 R16
        end
        if (req.rd) begin
            if (hit(req.addr, GMC_ADDR_GLOB_CTL)) begin
                st_nxt.rdata_r = {clk_sel_value, st_r.glob_r[GMC_BIT_EXT_IRQ_EN:0]};
            end else if (hit(req.addr, GMC_ADDR_MEM_CFG)) begin
                st_nxt.rdata_r = mem_cfg_value(st_r.boot_shadow_r); // R11 R12 R13
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r.glob_r <= GMC_GLOB_CTL_RESET; // R7
            st_r.boot_shadow_r <= 1'b0;
            st_r.rdata_r <= GMC_UNMAPPED_READ;
        end else begin
            st_r <= st_nxt;
        end
    end

    // External interrupt gating and merge
    gmc_irq_sync u_irq (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(ext_irq_pin),
        .enable(st_r.glob_r.ext_irq_enable), // R3
        .irq_out(ext_irq_gated)
    );

    assign cpu_interrupt_line = ext_irq_gated | internal_irq_any; // R17

    // Read data and control outputs
    assign reg_rdata = st_r.rdata_r;
    assign cpu_clock_speed_select = clk_sel_value; // R1
    assign port_one_pullup_off = st_r.glob_r.port_one_pullup_off; // R4
    assign port_three_pullup_off = st_r.glob_r.port_three_pullup_off; // R5
    assign gpio_out_bit4 = st_r.glob_r.gpio_out_bit4; // R6
    assign gpio_out_bit3 = st_r.glob_r.gpio_out_bit3; // R6
    assign usb_power_down = ~st_r.glob_r.usb_power_on; // R7
    assign codec_port_enable = st_r.glob_r.codec_port_enable; // R9
    assign boot_shadow = st_r.boot_shadow_r;
endmodule
`default_nettype wire

/* test/gmc_config_regs_sva.sv */
// Assertion checker for the global and memory configuration registers
`timescale 1ns/1ps
`default_nettype none
module gmc_config_regs_sva
    import gmc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Interrupts and boot-shadow protection
    input wire logic ext_irq_pin,
    input wire logic internal_irq_any,
    input wire logic cpu_interrupt_line,
    input wire logic ext_irq_gated,
    input wire logic boot_shadow_protect,
    // Controls
    input wire logic cpu_clock_speed_select,
    input wire logic port_one_pullup_off,
    input wire logic port_three_pullup_off,
    input wire logic gpio_out_bit4,
    input wire logic gpio_out_bit3,
    input wire logic usb_power_down,
    input wire logic codec_port_enable,
    input wire logic boot_shadow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic gw;
    logic mw;
    assign gw = reg_wr && reg_addr == GMC_ADDR_GLOB_CTL;
    assign mw = reg_wr && reg_addr == GMC_ADDR_MEM_CFG;
    // Shadow of the interrupt enable bit
    logic en_m;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            en_m <= 1'b0;
        end else if (gw) begin
            en_m <= reg_wdata[6];
        end
    end
    property p_clk_set; gw && reg_wdata[7] |=> cpu_clock_speed_select; endproperty
    a_clk_set: assert property (p_clk_set) else $error("clock select not set");
    property p_sticky; reset_n && cpu_clock_speed_select |=> cpu_clock_speed_select; endproperty
    a_sticky: assert property (p_sticky) else $error("clock select cleared");
    property p_irq_gate; $rose(ext_irq_gated) |-> $past(ext_irq_pin, 2); endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("gated irq without pin");
    property p_irq_en; ext_irq_gated |-> en_m; endproperty
    a_irq_en: assert property (p_irq_en) else $error("gated irq while disabled");
    property p_ctl; gw |=> {port_one_pullup_off, gpio_out_bit4, gpio_out_bit3,
        port_three_pullup_off, codec_port_enable} == {$past(reg_wdata[5:3]), $past(reg_wdata[1:0])};
    endproperty
    a_ctl: assert property (p_ctl) else $error("control bits wrong");
    property p_usb; gw |=> usb_power_down == !$past(reg_wdata[2]); endproperty
    a_usb: assert property (p_usb) else $error("usb power wrong");
    property p_mem_rd; reg_rd && reg_addr == GMC_ADDR_MEM_CFG |=>
        reg_rdata[7:1] == {GMC_CODE_MEM_KIND, GMC_CODE_SPACE_SIZE, GMC_SILICON_REV}; endproperty
    a_mem_rd: assert property (p_mem_rd) else $error("fixed fields wrong");
    property p_shadow; mw && !boot_shadow_protect |=> boot_shadow == $past(reg_wdata[0]); endproperty
    a_shadow: assert property (p_shadow) else $error("shadow not written");
    property p_protect; mw && boot_shadow_protect |=> $stable(boot_shadow); endproperty
    a_protect: assert property (p_protect) else $error("protected shadow changed");
    property p_irq_or; reset_n |->
        cpu_interrupt_line == (internal_irq_any || (en_m && $past(ext_irq_pin, 2)));
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("interrupt line wrong");
    cover property (gw && reg_wdata[7]);
    cover property ($rose(ext_irq_gated));
    cover property (mw && boot_shadow_protect);
endmodule
bind gmc_config_regs gmc_config_regs_sva u_sva (.*);
`default_nettype wire

/* test/gmc_config_regs_tb.sv */
// Testbench for the global and memory configuration registers
`timescale 1ns/1ps
`default_nettype none
module gmc_config_regs_tb
    import gmc_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ext_irq_pin = 1'b0;
    logic internal_irq_any = 1'b0;
    logic boot_shadow_protect = 1'b0;
    logic [7:0] reg_rdata;
    logic cpu_interrupt_line, ext_irq_gated, cpu_clock_speed_select, port_one_pullup_off;
    logic port_three_pullup_off, gpio_out_bit4, gpio_out_bit3, usb_power_down;
    logic codec_port_enable, boot_shadow;
    logic [7:0] outs;
    int miscompares = 0;
    int compares = 0;
    gmc_config_regs uut (.*);
    assign outs = {cpu_clock_speed_select, cpu_interrupt_line, port_one_pullup_off,
        gpio_out_bit4, gpio_out_bit3, usb_power_down, port_three_pullup_off, codec_port_enable};
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
        compares++;
        if (v !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata);
    endtask
    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #1000000;
        miscompares++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("outs", 8'h04, outs);
        rd(GMC_ADDR_GLOB_CTL, GMC_GLOB_CTL_RESET);
        rd(GMC_ADDR_MEM_CFG, 8'haa);
        rd(16'hffb2, GMC_UNMAPPED_READ);
        wr(GMC_ADDR_GLOB_CTL, 8'hbf);
        chk("outs", 8'hbb, outs);
        rd(GMC_ADDR_GLOB_CTL, 8'hbf);
        wr(GMC_ADDR_GLOB_CTL, 8'h00);
        chk("outs", 8'h84, outs);
        @(posedge clk) ext_irq_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("irq", 8'h00, {6'h00, ext_irq_gated, cpu_interrupt_line});
        wr(GMC_ADDR_GLOB_CTL, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", 8'h03, {6'h00, ext_irq_gated, cpu_interrupt_line});
        @(posedge clk) ext_irq_pin <= 1'b0;
        internal_irq_any <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("irq", 8'h01, {6'h00, ext_irq_gated, cpu_interrupt_line});
        @(posedge clk) internal_irq_any <= 1'b0;
        boot_shadow_protect <= 1'b1;
        wr(GMC_ADDR_MEM_CFG, 8'h01);
        chk("shadow", 8'h00, {7'h00, boot_shadow});
        @(posedge clk) boot_shadow_protect <= 1'b0;
        wr(GMC_ADDR_MEM_CFG, 8'h01);
        rd(GMC_ADDR_MEM_CFG, 8'hab);
        @(posedge clk) reset_n <= 1'b0;
        @(posedge clk) reset_n <= 1'b1;
        #1;
        chk("outs", 8'h04, outs);
        test_done;
    end
endmodule
`default_nettype wire
